// [core/uss_sync_serial.sv]
/*
 Synchronous half-duplex serial port: master and slave, transmit and receive,
 two-character receive FIFO with overrun, nine-bit characters, Wishbone registers.
 Assumes the pins are resolved outside from the output enables and that the
 clock and data line inputs are already synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module uss_sync_serial #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic data_line_i,
    output logic data_line_o,
    output logic data_line_oe,
    input wire logic clock_line_i,
    output logic clock_line_o,
    output logic clock_line_oe,
    output logic receive_flag_o
);
    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(FIFO_DEPTH - 1);

    logic [1:0] rstSyncQ;
    logic rstN;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstSyncQ <= 2'h0;
        end else begin
            rstSyncQ <= {rstSyncQ[0], 1'b1};
        end
    end
    assign rstN = rstSyncQ[1];

    // Control and status bits
    logic portEnQ, rx9Q, srenQ, crenQ, ovrQ, ovrCrenQ;
    logic csrcQ, tx9Q, txenQ, syncQ, brghQ, tx9dQ, sckpQ, brg16Q;
    logic [7:0] brgLoQ, brgHiQ, txBufQ;
    logic txBuf9Q, txFullQ;
    uss_pkg::uss_state_t stateQ;
    logic phaseQ, sclkQ, prevClkQ;
    logic [17:0] baudCntQ;
    logic [3:0] bitCntQ;
    logic [8:0] tsrQ, rxShQ;
    logic [8:0] fifoMem [FIFO_DEPTH];
    logic [PW-1:0] rdPtrQ, wrPtrQ;
    logic [CW-1:0] cntQ;
    logic [CW-1:0] cntD;

    // Bus decode
    logic busReq, wrEn, rdEn, popReq;
    assign busReq = wb_cyc_i & wb_stb_i;
    assign wrEn = busReq & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign rdEn = busReq & wb_ack_o & !wb_we_i;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] target);
        hit = (adr[7:2] == target[7:2]);
    endfunction : hit

    assign popReq = rdEn & hit(wb_adr_i, uss_pkg::ADDR_RECEIVE_DATA) & (cntQ != '0);

    // Mode decode
    logic active, master, slave, rxMode, tick, lead, trail, lastRx, lastTx;
    logic [3:0] rxBits, txBits;
    logic [17:0] reload;
    logic [8:0] rxNext, rxChar;
    logic rxDone, push, overrun, txTake, sampleOk;
    assign active = portEnQ & syncQ;
    assign master = active & csrcQ;
    assign slave = active & !csrcQ;
    assign rxMode = srenQ | crenQ;
    assign rxBits = rx9Q ? uss_pkg::BITS_LONG : uss_pkg::BITS_SHORT;
    assign txBits = txBuf9Q ? uss_pkg::BITS_LONG : uss_pkg::BITS_SHORT;
    assign lastRx = (bitCntQ == rxBits - 4'h1);
    assign lastTx = (bitCntQ == txBits - 4'h1);
    // Divider reload: 16-bit when wide, else low byte; slow rate prescales by four only when not wide
    always_comb begin
        reload = '0;
        if (brg16Q) begin
            reload[15:0] = {brgHiQ, brgLoQ};
        end else begin
            reload[7:0] = brgLoQ;
        end
        if (!(brghQ | brg16Q)) begin
            reload = {reload[15:0], 2'b11};
        end
    end
    assign tick = (baudCntQ == '0);
    // Slave edges relative to idle level
    assign lead = (clock_line_i != sckpQ) & (prevClkQ == sckpQ);
    assign trail = (clock_line_i == sckpQ) & (prevClkQ != sckpQ);
    assign rxNext = {data_line_i, rxShQ[8:1]};
    assign rxChar = rx9Q ? rxNext : {1'b0, rxNext[8:1]};
    assign sampleOk = (stateQ == uss_pkg::ST_MRX) ? (master & rxMode & !ovrQ & tick & phaseQ)
                    : ((stateQ == uss_pkg::ST_SRX) & slave & rxMode & !ovrQ & trail);
    assign rxDone = sampleOk & lastRx;
    assign push = rxDone & (cntQ != DEPTH_C);
    assign overrun = rxDone & (cntQ == DEPTH_C);
    assign txTake = (stateQ == uss_pkg::ST_IDLE) & active & !rxMode & txenQ & txFullQ;

    // Wishbone slave: ack one cycle after request, drops next cycle
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq & !wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (busReq & !wb_ack_o & !wb_we_i) begin
                if (hit(wb_adr_i, uss_pkg::ADDR_BAUD_CONTROL)) begin
                    wb_dat_o[uss_pkg::BC_CLOCK_POLARITY] <= sckpQ;
                    wb_dat_o[uss_pkg::BC_WIDE_DIVIDER] <= brg16Q;
                end
                if (hit(wb_adr_i, uss_pkg::ADDR_RECEIVE_STATUS_CONTROL)) begin
                    wb_dat_o[uss_pkg::RS_PORT_ENABLE] <= portEnQ;
                    wb_dat_o[uss_pkg::RS_NINE_BIT_RX] <= rx9Q;
                    wb_dat_o[uss_pkg::RS_SINGLE_RX] <= srenQ;
                    wb_dat_o[uss_pkg::RS_CONT_RX] <= crenQ;
                    wb_dat_o[uss_pkg::RS_OVERRUN] <= ovrQ;
                    wb_dat_o[uss_pkg::RS_RX_NINTH] <= fifoMem[rdPtrQ][8] & (cntQ != '0);
                end
                if (hit(wb_adr_i, uss_pkg::ADDR_BAUD_DIVISOR_LOW)) begin
                    wb_dat_o[7:0] <= brgLoQ;
                end
                if (hit(wb_adr_i, uss_pkg::ADDR_BAUD_DIVISOR_HIGH)) begin
                    wb_dat_o[7:0] <= brgHiQ;
                end
                if (hit(wb_adr_i, uss_pkg::ADDR_TRANSMIT_STATUS_CONTROL)) begin
                    wb_dat_o[uss_pkg::TS_MASTER_CLOCK] <= csrcQ;
                    wb_dat_o[uss_pkg::TS_NINE_BIT_TX] <= tx9Q;
                    wb_dat_o[uss_pkg::TS_TX_ENABLE] <= txenQ;
                    wb_dat_o[uss_pkg::TS_CLOCKED_MODE] <= syncQ;
                    wb_dat_o[uss_pkg::TS_HIGH_SPEED] <= brghQ;
                    wb_dat_o[uss_pkg::TS_SHIFT_EMPTY] <= (stateQ != uss_pkg::ST_MTX) & (stateQ != uss_pkg::ST_STX);
                    wb_dat_o[uss_pkg::TS_TX_NINTH] <= tx9dQ;
                end
                if (hit(wb_adr_i, uss_pkg::ADDR_RECEIVE_DATA) & (cntQ != '0)) begin
                    wb_dat_o[7:0] <= fifoMem[rdPtrQ][7:0];
                end
                if (hit(wb_adr_i, uss_pkg::ADDR_LINE_STATUS)) begin
                    wb_dat_o[uss_pkg::LS_RECEIVE_FLAG] <= receive_flag_o;
                    wb_dat_o[uss_pkg::LS_TX_BUFFER_FULL] <= txFullQ;
                end
            end
        end
    end

    // Software control bits; the single receive enable self-clears after a master-mode character
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            {portEnQ, rx9Q, srenQ, crenQ} <= 4'h0;
            {csrcQ, tx9Q, txenQ, syncQ, brghQ, tx9dQ, sckpQ, brg16Q} <= uss_pkg::RESET_BYTE;
            brgLoQ <= uss_pkg::RESET_BYTE;
            brgHiQ <= uss_pkg::RESET_BYTE;
        end else begin
            if (rxDone & (stateQ == uss_pkg::ST_MRX)) begin
                srenQ <= 1'b0;
            end
            if (wrEn & hit(wb_adr_i, uss_pkg::ADDR_BAUD_CONTROL)) begin
                sckpQ <= wb_dat_i[uss_pkg::BC_CLOCK_POLARITY];
                brg16Q <= wb_dat_i[uss_pkg::BC_WIDE_DIVIDER];
            end
            if (wrEn & hit(wb_adr_i, uss_pkg::ADDR_RECEIVE_STATUS_CONTROL)) begin
                portEnQ <= wb_dat_i[uss_pkg::RS_PORT_ENABLE];
                rx9Q <= wb_dat_i[uss_pkg::RS_NINE_BIT_RX];
                srenQ <= wb_dat_i[uss_pkg::RS_SINGLE_RX];
                crenQ <= wb_dat_i[uss_pkg::RS_CONT_RX];
            end
            if (wrEn & hit(wb_adr_i, uss_pkg::ADDR_BAUD_DIVISOR_LOW)) begin
                brgLoQ <= wb_dat_i[7:0];
            end
            if (wrEn & hit(wb_adr_i, uss_pkg::ADDR_BAUD_DIVISOR_HIGH)) begin
                brgHiQ <= wb_dat_i[7:0];
            end
            if (wrEn & hit(wb_adr_i, uss_pkg::ADDR_TRANSMIT_STATUS_CONTROL)) begin
                csrcQ <= wb_dat_i[uss_pkg::TS_MASTER_CLOCK];
                tx9Q <= wb_dat_i[uss_pkg::TS_NINE_BIT_TX];
                txenQ <= wb_dat_i[uss_pkg::TS_TX_ENABLE];
                syncQ <= wb_dat_i[uss_pkg::TS_CLOCKED_MODE];
                brghQ <= wb_dat_i[uss_pkg::TS_HIGH_SPEED];
                tx9dQ <= wb_dat_i[uss_pkg::TS_TX_NINTH];
            end
        end
    end

    // Transmit holding register
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            txBufQ <= uss_pkg::RESET_BYTE;
            txBuf9Q <= 1'b0;
            txFullQ <= 1'b0;
        end else if (!portEnQ) begin
            txFullQ <= 1'b0;
        end else if (wrEn & hit(wb_adr_i, uss_pkg::ADDR_TRANSMIT_DATA)) begin
            txBufQ <= wb_dat_i[7:0];
            txBuf9Q <= tx9Q;
            txFullQ <= 1'b1;
        end else if (txTake) begin
            txFullQ <= 1'b0;
        end
    end

    // Overrun flag; set wins over every clear
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ovrQ <= 1'b0;
            ovrCrenQ <= 1'b0;
        end else if (overrun) begin
            ovrQ <= 1'b1;
            ovrCrenQ <= crenQ;
        end else if (!portEnQ) begin
            ovrQ <= 1'b0;
        end else if (ovrCrenQ & !crenQ) begin
            ovrQ <= 1'b0;
        end else if (!ovrCrenQ & rdEn & hit(wb_adr_i, uss_pkg::ADDR_RECEIVE_DATA)) begin
            ovrQ <= 1'b0;
        end
    end

    // Receive FIFO; full FIFO refuses the new character and keeps its contents
    always_comb begin
        cntD = cntQ;
        if (push & !popReq) begin
            cntD = cntQ + CW'(1);
        end else if (popReq & !push) begin
            cntD = cntQ - CW'(1);
        end
    end
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rdPtrQ <= '0;
            wrPtrQ <= '0;
            cntQ <= '0;
            receive_flag_o <= 1'b0;
        end else if (!portEnQ) begin
            rdPtrQ <= '0;
            wrPtrQ <= '0;
            cntQ <= '0;
            receive_flag_o <= 1'b0;
        end else begin
            if (push) begin
                wrPtrQ <= (wrPtrQ == LAST_PTR) ? '0 : wrPtrQ + PW'(1);
            end
            if (popReq) begin
                rdPtrQ <= (rdPtrQ == LAST_PTR) ? '0 : rdPtrQ + PW'(1);
            end
            cntQ <= cntD;
            receive_flag_o <= (cntD != '0);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (push) begin
            fifoMem[wrPtrQ] <= rxChar;
        end
    end

    // Shift engine for both roles
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            stateQ <= uss_pkg::ST_IDLE;
            phaseQ <= 1'b0;
            baudCntQ <= '0;
            bitCntQ <= 4'h0;
            tsrQ <= '0;
            rxShQ <= '0;
            sclkQ <= 1'b0;
            prevClkQ <= 1'b0;
            data_line_o <= 1'b0;
        end else begin
            prevClkQ <= clock_line_i;
            baudCntQ <= tick ? reload : baudCntQ - 18'h0_0001;
            unique case (stateQ)
                uss_pkg::ST_IDLE: begin
                    sclkQ <= sckpQ;
                    phaseQ <= 1'b0;
                    bitCntQ <= 4'h0;
                    baudCntQ <= reload;
                    if (master & rxMode & !ovrQ) begin
                        stateQ <= uss_pkg::ST_MRX;
                    end else if (slave & rxMode & !ovrQ) begin
                        stateQ <= uss_pkg::ST_SRX;
                    end else if (txTake) begin
                        tsrQ <= {txBuf9Q & tx9dQ, txBufQ};
                        stateQ <= master ? uss_pkg::ST_MTX : uss_pkg::ST_STX;
                    end
                end
                uss_pkg::ST_MRX, uss_pkg::ST_MTX: begin
                    if (!master | ovrQ | ((stateQ == uss_pkg::ST_MRX) != rxMode)) begin
                        stateQ <= uss_pkg::ST_IDLE;
                        sclkQ <= sckpQ;
                    end else if (tick & !phaseQ) begin
                        sclkQ <= !sckpQ;
                        phaseQ <= 1'b1;
                        if (stateQ == uss_pkg::ST_MTX) begin
                            data_line_o <= tsrQ[0];
                            tsrQ <= {1'b0, tsrQ[8:1]};
                        end
                    end else if (tick) begin
                        sclkQ <= sckpQ;
                        phaseQ <= 1'b0;
                        bitCntQ <= bitCntQ + 4'h1;
                        if (stateQ == uss_pkg::ST_MRX) begin
                            rxShQ <= rxNext;
                            if (lastRx) begin
                                bitCntQ <= 4'h0;
                                stateQ <= crenQ ? uss_pkg::ST_MRX : uss_pkg::ST_IDLE;
                            end
                        end else if (lastTx) begin
                            stateQ <= uss_pkg::ST_IDLE;
                        end
                    end
                end
                uss_pkg::ST_SRX: begin
                    if (!slave | !rxMode | ovrQ) begin
                        stateQ <= uss_pkg::ST_IDLE;
                    end else if (trail) begin
                        rxShQ <= rxNext;
                        bitCntQ <= lastRx ? 4'h0 : bitCntQ + 4'h1;
                    end
                end
                uss_pkg::ST_STX: begin
                    if (!slave | rxMode) begin
                        stateQ <= uss_pkg::ST_IDLE;
                    end else if (lead) begin
                        data_line_o <= tsrQ[0];
                        tsrQ <= {1'b0, tsrQ[8:1]};
                    end else if (trail) begin
                        bitCntQ <= bitCntQ + 4'h1;
                        if (lastTx) begin
                            stateQ <= uss_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Pin drivers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            data_line_oe <= 1'b0;
            clock_line_oe <= 1'b0;
        end else begin
            data_line_oe <= active & !rxMode & txenQ;
            clock_line_oe <= master;
        end
    end
    // Pin clock is the shift flop itself, so sampling meets the pin's trailing edge
    assign clock_line_o = sclkQ;
endmodule : uss_sync_serial

`default_nettype wire

// [include/uss_pkg.sv]
/*
 Register map, field positions and reset values of the synchronous serial port.
 Assumes a 32-bit Wishbone slave with byte addresses; each register is one aligned word.
*/
package uss_pkg;
    localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_RECEIVE_STATUS_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_BAUD_DIVISOR_LOW = 8'h08;
    localparam logic [7:0] ADDR_BAUD_DIVISOR_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_TRANSMIT_DATA = 8'h10;
    localparam logic [7:0] ADDR_TRANSMIT_STATUS_CONTROL = 8'h14;
    localparam logic [7:0] ADDR_RECEIVE_DATA = 8'h18;
    localparam logic [7:0] ADDR_LINE_STATUS = 8'h1C;

    // baud_control
    localparam int BC_CLOCK_POLARITY = 4;
    localparam int BC_WIDE_DIVIDER = 3;
    // receive_status_control
    localparam int RS_PORT_ENABLE = 7;
    localparam int RS_NINE_BIT_RX = 6;
    localparam int RS_SINGLE_RX = 5;
    localparam int RS_CONT_RX = 4;
    localparam int RS_OVERRUN = 1;
    localparam int RS_RX_NINTH = 0;
    // transmit_status_control
    localparam int TS_MASTER_CLOCK = 7;
    localparam int TS_NINE_BIT_TX = 6;
    localparam int TS_TX_ENABLE = 5;
    localparam int TS_CLOCKED_MODE = 4;
    localparam int TS_HIGH_SPEED = 2;
    localparam int TS_SHIFT_EMPTY = 1;
    localparam int TS_TX_NINTH = 0;
    // line_status
    localparam int LS_RECEIVE_FLAG = 0;
    localparam int LS_TX_BUFFER_FULL = 1;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] BITS_SHORT = 4'h8;
    localparam logic [3:0] BITS_LONG = 4'h9;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_MTX,
        ST_MRX,
        ST_STX,
        ST_SRX
    } uss_state_t;
endpackage : uss_pkg

// [tb/uss_far_end.sv]
/*
 Far-end model: another synchronous serial party on the clock and data lines.
 Assumes the bench resolves both wires from the port's output enables.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_far_end (
    input wire logic clk_sys,
    input wire logic clkWire,
    input wire logic dataWire,
    input wire logic devDrives,
    input wire logic pol,
    output logic dataOut,
    output logic clkOut
);
    logic prevQ, phaseQ;
    logic [8:0] rxWord;
    int edges, rxCnt;
    logic txQ[$];
    initial begin
        prevQ = 1'h0;
        phaseQ = 1'h0;
        dataOut = 1'h0;
    end
    assign clkOut = phaseQ ^ pol;
    task automatic clr();
        edges = 0;
        rxCnt = 0;
        txQ.delete();
    endtask : clr
    task automatic load(input logic [8:0] v, input int n);
        for (int i = 0; i < n; i++) txQ.push_back(v[i]);
    endtask : load
    // Clock as master: only within a frame, one cycle per bit
    task automatic clocks(input int n);
        repeat (2 * n) begin
            repeat (3) @(posedge clk_sys);
            phaseQ <= ~phaseQ;
        end
    endtask : clocks
    always @(posedge clk_sys) begin
        prevQ <= clkWire;
        if (prevQ == pol && clkWire != pol) begin
            // Leading edge: next bit, or a changing pattern once drained
            if (txQ.size() > 0) dataOut <= txQ.pop_front();
            else dataOut <= ~dataOut;
        end
        if (prevQ != pol && clkWire == pol) begin
            edges++;
            if (devDrives) begin
                rxWord <= {dataWire, rxWord[8:1]};
                rxCnt++;
            end
        end
    end
endmodule : uss_far_end
`default_nettype wire

// [tb/uss_sync_serial_properties.sv]
/*
 Checker for the serial port's bus and pin relations.
 Bound to uss_sync_serial; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_sync_serial_checker #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic data_line_oe,
    input wire logic clock_line_o,
    input wire logic clock_line_oe,
    input wire logic receive_flag_o
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic wr, contQ, masterQ, polQ;
    logic [3:0] popAge;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    // Shadow of control bits as software wrote them
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            contQ <= 1'h0;
            masterQ <= 1'h0;
            polQ <= 1'h0;
        end else if (wr) begin
            if (wb_adr_i == uss_pkg::ADDR_RECEIVE_STATUS_CONTROL) contQ <= wb_dat_i[uss_pkg::RS_CONT_RX];
            if (wb_adr_i == uss_pkg::ADDR_TRANSMIT_STATUS_CONTROL) masterQ <= wb_dat_i[uss_pkg::TS_MASTER_CLOCK];
            if (wb_adr_i == uss_pkg::ADDR_BAUD_CONTROL) polQ <= wb_dat_i[uss_pkg::BC_CLOCK_POLARITY];
        end
    end
    // Cycles since the last data read or port disable
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) popAge <= 4'hF;
        else if (wb_ack_o && !wb_we_i && wb_adr_i == uss_pkg::ADDR_RECEIVE_DATA) popAge <= 4'h0;
        else if (wr && wb_adr_i == uss_pkg::ADDR_RECEIVE_STATUS_CONTROL && !wb_dat_i[7]) popAge <= 4'h0;
        else if (popAge != 4'hF) popAge <= popAge + 4'h1;
    end
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_idle_dat_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_unmapped_zero: assert property (wb_ack_o && wb_adr_i[7:5] != 3'h0 |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_slave_clock_off: assert property (!masterQ && !$past(masterQ, 2) |-> !clock_line_oe)
        else $error("clock driven as slave");
    a_rx_data_release: assert property (contQ && $past(contQ, 2) |-> !data_line_oe)
        else $error("data line driven while receiving");
    a_flag_on_read: assert property ($fell(receive_flag_o) |-> popAge <= 4'h4)
        else $error("receive flag fell without a read");
    a_clock_stop_now: assert property (wr && wb_adr_i == uss_pkg::ADDR_RECEIVE_STATUS_CONTROL
        && !wb_dat_i[uss_pkg::RS_CONT_RX] && !wb_dat_i[uss_pkg::RS_SINGLE_RX]
        |-> ##[1:3] (!clock_line_oe || clock_line_o == polQ) [*4]) else $error("clock ran after receive off");
    c_flag: cover property ($rose(receive_flag_o));
    c_master_clock: cover property ($rose(clock_line_oe));
    c_pop: cover property (wb_ack_o && !wb_we_i && wb_adr_i == uss_pkg::ADDR_RECEIVE_DATA);
endmodule : uss_sync_serial_checker
bind uss_sync_serial uss_sync_serial_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .data_line_oe(data_line_oe),
    .clock_line_o(clock_line_o), .clock_line_oe(clock_line_oe), .receive_flag_o(receive_flag_o));
`default_nettype wire

// [tb/uss_sync_serial_tb_top.sv]
/*
 Bench for the synchronous serial port: Wishbone master tasks, a queue model
 of the receive FIFO and the far-end model on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module uss_sync_serial_tb_top;
    logic clk_sys, arst_n, wbCyc, wbStb, wbWe, wbAck, dataO, dataOe, clkO, clkOe, rxFlag, pol, farData, farClk;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO, rd;
    logic [8:0] v;
    wire dataWire;
    wire clkWire;
    int num_errors, tests_run, cycles, n;
    int q[$];
    assign dataWire = dataOe ? dataO : farData;
    assign clkWire = clkOe ? clkO : farClk;
    uss_sync_serial dut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .data_line_i(dataWire), .data_line_o(dataO), .data_line_oe(dataOe), .clock_line_i(clkWire),
        .clock_line_o(clkO), .clock_line_oe(clkOe), .receive_flag_o(rxFlag));
    uss_far_end far (.clk_sys(clk_sys), .clkWire(clkWire), .dataWire(dataWire), .devDrives(dataOe), .pol(pol),
        .dataOut(farData), .clkOut(farClk));
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // One classic cycle; holds everything until ack is sampled
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wbCyc <= 1'h1;
        wbStb <= 1'h1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        @(posedge clk_sys);
        while (wbAck !== 1'h1 && k < 100) begin
            @(posedge clk_sys);
            k++;
        end
        check({31'h0, wbAck}, 32'h1, "bus ack");
        rd = wbDatO;
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
        @(posedge clk_sys);
    endtask : bus
    task automatic poll(input logic [7:0] a, input int b, input logic val);
        int k;
        k = 0;
        bus(1'h0, a, 32'h0);
        while (rd[b] !== val && k < 300) begin
            bus(1'h0, a, 32'h0);
            k++;
        end
        check({31'h0, rd[b]}, {31'h0, val}, "status bit");
    endtask : poll
    initial begin
        clk_sys = 1'h0;
        arst_n = 1'h0;
        {wbCyc, wbStb, wbWe, pol} = 4'h0;
        wbAdr = 8'h00;
        wbSel = 4'hF;
        wbDatI = 32'h0;
        v = 9'($urandom(32'h49d1_e321));
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
        bus(1'h1, 8'h20, 32'hFFFF_FFFF);
        for (int a = 0; a <= 32; a += 4) begin
            bus(1'h0, 8'(a), 32'h0);
            check(rd, (a == 20) ? 32'h0000_0002 : 32'h0000_0000, "reset value");
        end
        v = 9'($urandom);
        bus(1'h1, 8'h0C, {24'h0, v[7:0]});
        bus(1'h0, 8'h0C, 32'h0);
        check(rd, {24'h0, v[7:0]}, "divisor high");
        bus(1'h1, 8'h08, 32'h1);
        bus(1'h1, 8'h14, 32'h94);
        bus(1'h1, 8'h04, 32'h80);
        for (int i = 0; i < 3; i++) begin
            v = 9'($urandom);
            far.clr();
            far.load(v, 8);
            bus(1'h1, 8'h04, 32'hA0);
            poll(8'h04, 5, 1'h0);
            check(far.edges, 8, "clocks per character");
            if (q.size() < 2) q.push_back(v[7:0]);
        end
        poll(8'h1C, 0, 1'h1);
        poll(8'h04, 1, 1'h1);
        bus(1'h0, 8'h18, 32'h0);
        check(rd, q.pop_front(), "first held character");
        poll(8'h04, 1, 1'h0);
        bus(1'h0, 8'h18, 32'h0);
        check(rd, q.pop_front(), "second held character");
        check({31'h0, rxFlag}, 32'h0, "flag after drain");
        far.clr();
        bus(1'h1, 8'h04, 32'h90);
        repeat (20) @(posedge clk_sys);
        bus(1'h1, 8'h04, 32'h80);
        repeat (20) @(posedge clk_sys);
        check(32'(far.edges < 8), 32'h1, "abort mid character");
        check({31'h0, rxFlag}, 32'h0, "partial character dropped");
        far.clr();
        for (int i = 0; i < 2; i++) begin
            v = 9'($urandom);
            q.push_back(v);
            far.load(v, 9);
        end
        bus(1'h1, 8'h04, 32'hD0);
        poll(8'h04, 1, 1'h1);
        repeat (50) @(posedge clk_sys);
        check(far.edges, 27, "clocks until overrun");
        bus(1'h1, 8'h04, 32'hC0);
        while (q.size() > 0) begin
            bus(1'h0, 8'h04, 32'h0);
            check(rd[1:0], {1'h0, q[0][8]}, "ninth bit");
            bus(1'h0, 8'h18, 32'h0);
            check(rd, q.pop_front() & 32'h0000_00FF, "nine-bit data");
        end
        pol <= 1'h1;
        bus(1'h1, 8'h00, 32'h10);
        bus(1'h1, 8'h14, 32'hB4);
        far.clr();
        check({31'h0, clkO}, 32'h1, "clock idles high");
        v = 9'($urandom);
        bus(1'h1, 8'h10, {24'h0, v[7:0]});
        n = 0;
        while (far.rxCnt < 8 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (20) @(posedge clk_sys);
        check(far.rxWord[8:1], v[7:0], "transmitted byte");
        check(far.edges, 8, "transmit clocks");
        bus(1'h1, 8'h14, 32'h10);
        bus(1'h1, 8'h04, 32'h90);
        check({31'h0, clkOe}, 32'h0, "slave clock driver");
        far.clr();
        v = 9'($urandom);
        far.load(v, 8);
        far.clocks(8);
        repeat (10) @(posedge clk_sys);
        bus(1'h0, 8'h18, 32'h0);
        check(rd, {24'h0, v[7:0]}, "slave received byte");
        bus(1'h1, 8'h04, 32'h80);
        bus(1'h1, 8'h14, 32'h30);
        far.clr();
        v = 9'($urandom);
        bus(1'h1, 8'h10, {24'h0, v[7:0]});
        far.clocks(8);
        repeat (10) @(posedge clk_sys);
        check(far.rxWord[8:1], v[7:0], "slave sent byte");
        check(far.rxCnt, 8, "slave bits per clock");
        check({31'h0, clkOe}, 32'h0, "slave transmit clock driver");
        stop_test();
    end
endmodule : uss_sync_serial_tb_top
`default_nettype wire
